// >>> verilog/wfsu_defines.vh
`ifndef WFSU_DEFINES_VH
`define WFSU_DEFINES_VH

// Register byte offsets
`define WFSU_CTRL_OFS 8'h00
`define WFSU_CMD_OFS 8'h04
`define WFSU_STAT_OFS 8'h08
`define WFSU_THR_OFS 8'h0C
`define WFSU_DERIV_OFS 8'h10
`define WFSU_SRC_OFS 8'h14
`define WFSU_OMAP_OFS 8'h18
`define WFSU_WGT_OFS 8'h1C
`define WFSU_FLOW_OFS 8'h20
`define WFSU_DISP_OFS 8'h24
`define WFSU_LVL0_OFS 8'h30
`define WFSU_LVL1_OFS 8'h34
`define WFSU_LVL2_OFS 8'h38
`define WFSU_LVL3_OFS 8'h3C

// Control register fields
`define WFSU_CTRL_BW_LSB 0
`define WFSU_CTRL_FLOWEN_BIT 4
`define WFSU_CTRL_ZTEN_BIT 5
`define WFSU_CTRL_SCALE_LSB 6
`define WFSU_CTRL_DEC_LSB 9
`define WFSU_CTRL_STEP_LSB 11

// Command register fields
`define WFSU_CMD_ARM_LSB 0
`define WFSU_CMD_CANCEL_LSB 4
`define WFSU_CMD_TOGGLE_BIT 8

// Reset values
`define WFSU_CTRL_RST 32'h0000_0000
`define WFSU_THR_RST 32'h0000_0064
`define WFSU_DERIV_RST 16'h0064
`define WFSU_ZERO32 32'h0000_0000

// Bandwidth codes: 0=50,1=30,2=15,3=8,4=4,5=2,6=1,7=0.5,8=0.25,9=0.125 Hz
`define WFSU_BW_1HZ 4'h6
`define WFSU_BW_LOW_FIRST 4'h7
`define WFSU_BW_LAST 4'h9

// Timing
`define WFSU_CLK_HZ 40000000
`define WFSU_SAMPLE_HZ 300
`define WFSU_SAMPLE_CYC (`WFSU_CLK_HZ / `WFSU_SAMPLE_HZ)
`define WFSU_STEP_MS 100
`define WFSU_STEP_SAMPLES (`WFSU_STEP_MS * `WFSU_SAMPLE_HZ / 1000)
`define WFSU_FLOW_RATE_K 100
`define WFSU_SEC_PER_MIN 60
`define WFSU_SEC_PER_HOUR 3600
`define WFSU_KILO 1000

`endif

// >>> verilog/wfsu_top.v
`timescale 1ns/10ps
`include "wfsu_defines.vh"

module wfsu_top #(
  parameter SAMPLE_CYC = `WFSU_SAMPLE_CYC,
  parameter TD_MAX = 30000,
  parameter HIST_DEPTH = `WFSU_FLOW_RATE_K
) (
  input wire clk,
  input wire nrst,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  input wire wb_we_i,
  input wire [3:0] wb_sel_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output wire wb_ack_o,
  input wire [23:0] raw_weight_i,
  input wire wf_toggle_key_i,
  output wire [3:0] dout_o,
  output wire zero_track_en_o,
  output wire show_flow_o,
  output wire flow_kilo_unit_o,
  output wire flow_valid_o,
  output wire sample_tick_o,
  output wire [31:0] weight_o,
  output wire [31:0] flow_o
);

  localparam DV_IDLE = 2'b01;
  localparam DV_BUSY = 2'b10;

  // Byte-lane merge for Wishbone writes
  function [31:0] wfsu_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] sel;
    integer b;
    begin
      wfsu_merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          wfsu_merge[b*8 +: 8] = new_v[b*8 +: 8];
        end
      end
    end
  endfunction

  integer i;

  // Bus and configuration state
  reg ack_r;
  reg [31:0] ctrl_r;
  reg [31:0] thr_r;
  reg [7:0] src_r;
  reg [11:0] omap_r;
  reg [31:0] level_r [0:3];
  reg [15:0] td_neff_r;
  reg [8:0] td_u_r;
  reg [6:0] td_e_r;
  reg [3:0] armed_r;
  reg [3:0] reached_r;
  reg show_flow_r;

  // Sampling and filter state
  reg [23:0] w_s1_r;
  reg [23:0] w_s2_r;
  reg [23:0] w_s3_r;
  reg [23:0] w_q_r;
  reg key_s1_r;
  reg key_s2_r;
  reg key_d_r;
  reg [17:0] tick_cnt_r;
  reg tick_r;
  reg [39:0] filt_r;
  reg [31:0] snap_r;
  reg [5:0] step_cnt_r;
  reg wide_r;

  // Flow state
  reg [31:0] hist_r [0:HIST_DEPTH-1];
  reg [6:0] ptr_r;
  reg [6:0] fill_r;
  reg [8:0] ucnt_r;
  reg [1:0] dv_st_r;
  reg [6:0] dv_cnt_r;
  reg [63:0] dv_quo_r;
  reg [32:0] dv_rem_r;
  reg [31:0] dv_div_r;
  reg dv_neg_r;
  reg [31:0] flow_r;
  reg flow_valid_r;

  wire req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wr = req & wb_we_i;
  wire [3:0] bw_code = ctrl_r[`WFSU_CTRL_BW_LSB +: 4];
  wire flow_en = ctrl_r[`WFSU_CTRL_FLOWEN_BIT];
  wire [2:0] scale = ctrl_r[`WFSU_CTRL_SCALE_LSB +: 3];
  wire [1:0] dec = ctrl_r[`WFSU_CTRL_DEC_LSB +: 2];
  wire [1:0] stepc = ctrl_r[`WFSU_CTRL_STEP_LSB +: 2];
  wire kilo = (scale == 3'd3) | (scale == 3'd4);
  wire [31:0] weight_v = {{8{filt_r[39]}}, filt_r[39:16]};
  wire [31:0] disp_v = show_flow_r ? flow_r : weight_v;

  assign wb_ack_o = ack_r;
  assign show_flow_o = show_flow_r;
  assign flow_kilo_unit_o = kilo;
  assign flow_valid_o = flow_valid_r;
  assign sample_tick_o = tick_r;
  assign weight_o = weight_v;
  assign flow_o = flow_r;
  // Zero tracking only runs while no setpoint is armed
  assign zero_track_en_o = ctrl_r[`WFSU_CTRL_ZTEN_BIT] & ~(|armed_r);

  // Each enabled output follows the armed state of its assigned channel; a disabled one stays low
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_dout
      assign dout_o[g] = omap_r[g*3+2] & armed_r[omap_r[g*3 +: 2]];
    end
  endgenerate

  // Pin synchronisers; the first stage feeds only the second
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      w_s1_r <= 24'h00_0000;
      w_s2_r <= 24'h00_0000;
      w_s3_r <= 24'h00_0000;
      w_q_r <= 24'h00_0000;
      key_s1_r <= 1'b0;
      key_s2_r <= 1'b0;
      key_d_r <= 1'b0;
    end else begin
      w_s1_r <= raw_weight_i;
      w_s2_r <= w_s1_r;
      w_s3_r <= w_s2_r;
      // Word taken only when two synchronised copies agree, so a torn
      // capture of the asynchronous bus never reaches the filter
      if (w_s2_r == w_s3_r) begin
        w_q_r <= w_s3_r;
      end
      key_s1_r <= wf_toggle_key_i;
      key_s2_r <= key_s1_r;
      key_d_r <= key_s2_r;
    end
  end

  // Sample rate divider, one pulse per weight sample
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_r <= 18'h0_0000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == SAMPLE_CYC - 1) begin
      tick_cnt_r <= 18'h0_0000;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 18'h0_0001;
      tick_r <= 1'b0;
    end
  end

  // Step detector: raw samples compared 100 ms apart
  wire [31:0] raw_ext = {{8{w_q_r[23]}}, w_q_r};
  wire [31:0] step_d = raw_ext - snap_r;
  wire [31:0] step_abs = step_d[31] ? (~step_d + 32'h0000_0001) : step_d;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      snap_r <= `WFSU_ZERO32;
      step_cnt_r <= 6'h00;
      wide_r <= 1'b0;
    end else if (tick_r) begin
      if (step_cnt_r == `WFSU_STEP_SAMPLES - 1) begin
        step_cnt_r <= 6'h00;
        snap_r <= raw_ext;
        wide_r <= (step_abs > thr_r);
      end else begin
        step_cnt_r <= step_cnt_r + 6'h01;
      end
    end
  end

  // Fallback to 1 Hz only from the three lowest bandwidths
  wire use_wide = wide_r & (bw_code >= `WFSU_BW_LOW_FIRST);
  wire [3:0] bw_raw = (bw_code > `WFSU_BW_LAST) ? `WFSU_BW_LAST : bw_code;
  wire [3:0] bw_eff = use_wide ? `WFSU_BW_1HZ : bw_raw;

  // First-order low pass, coefficient 2^-code; each code halves bandwidth
  // roughly, so settling time tracks the rise-time table within a sample
  wire [39:0] filt_in = {w_q_r, 16'h0000};
  wire [39:0] filt_err = filt_in - filt_r;
  wire [39:0] filt_adj = $signed(filt_err) >>> bw_eff;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      filt_r <= 40'h00_0000_0000;
    end else if (tick_r) begin
      filt_r <= filt_r + filt_adj;
    end
  end

  // Derivation time rounding to the achievable update grid
  wire [31:0] deriv_m = wfsu_merge({16'h0000, td_neff_r}, wb_dat_i, wb_sel_i);
  wire [31:0] omap_m = wfsu_merge({20'h0_0000, omap_r}, wb_dat_i, wb_sel_i);
  wire [15:0] td_lo = (deriv_m[15:0] == 16'h0000) ? 16'h0001 : deriv_m[15:0];
  wire [15:0] td_req = (deriv_m[31:16] != 16'h0000 || td_lo > TD_MAX) ?
                       TD_MAX[15:0] : td_lo;
  wire [15:0] td_u16 = (td_req + 16'd50) / 16'd100;
  wire deriv_wr = wr && (wb_adr_i == `WFSU_DERIV_OFS);

  // Per-channel compared signal; a hit is looked at once per sample while armed
  reg [31:0] sp_val;
  reg [3:0] sp_hit;
  integer j;
  always @* begin
    sp_val = `WFSU_ZERO32;
    sp_hit = 4'h0;
    for (j = 0; j < 4; j = j + 1) begin
      case (src_r[j*2 +: 2])
        2'd0: sp_val = weight_v;
        2'd1: sp_val = weight_v[31] ? (~weight_v + 32'h0000_0001) : weight_v;
        2'd2: sp_val = flow_r;
        default: sp_val = disp_v;
      endcase
      sp_hit[j] = tick_r & armed_r[j] & ($signed(sp_val) > $signed(level_r[j]));
    end
  end

  // Register writes, commands and setpoint supervision
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
      ctrl_r <= `WFSU_CTRL_RST;
      thr_r <= `WFSU_THR_RST;
      src_r <= 8'h00;
      omap_r <= 12'h000;
      td_neff_r <= `WFSU_DERIV_RST;
      td_u_r <= 9'h001;
      td_e_r <= 7'd100;
      armed_r <= 4'h0;
      reached_r <= 4'h0;
      show_flow_r <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        level_r[i] <= `WFSU_ZERO32;
      end
    end else begin
      ack_r <= req;
      if (wr && wb_adr_i == `WFSU_CTRL_OFS) begin
        ctrl_r <= wfsu_merge(ctrl_r, wb_dat_i, wb_sel_i);
      end
      if (wr && wb_adr_i == `WFSU_THR_OFS) begin
        thr_r <= wfsu_merge(thr_r, wb_dat_i, wb_sel_i);
      end
      if (wr && wb_adr_i == `WFSU_SRC_OFS) begin
        src_r <= wb_sel_i[0] ? wb_dat_i[7:0] : src_r;
      end
      if (wr && wb_adr_i == `WFSU_OMAP_OFS) begin
        omap_r <= omap_m[11:0];
      end
      if (deriv_wr) begin
        if (td_req <= 16'd100) begin
          td_u_r <= 9'h001;
          td_e_r <= td_req[6:0];
          td_neff_r <= td_req;
        end else begin
          td_u_r <= td_u16[8:0];
          td_e_r <= 7'd100;
          td_neff_r <= td_u16 * 16'd100;
        end
      end
      // Toggle from key edge or command; unavailable with flow off
      if (!flow_en) begin
        show_flow_r <= 1'b0;
      end else if ((key_s2_r & ~key_d_r) |
                   (wr && wb_adr_i == `WFSU_CMD_OFS && wb_sel_i[1] &&
                    wb_dat_i[`WFSU_CMD_TOGGLE_BIT])) begin
        show_flow_r <= ~show_flow_r;
      end
      for (i = 0; i < 4; i = i + 1) begin
        if (wr && wb_adr_i == (`WFSU_LVL0_OFS + i * 4)) begin
          level_r[i] <= wfsu_merge(level_r[i], wb_dat_i, wb_sel_i);
        end
        if (wr && wb_adr_i == `WFSU_CMD_OFS && wb_sel_i[0] &&
            wb_dat_i[`WFSU_CMD_ARM_LSB + i]) begin
          armed_r[i] <= 1'b1;
          reached_r[i] <= 1'b0;
        end else if (sp_hit[i]) begin
          armed_r[i] <= 1'b0;
          reached_r[i] <= 1'b1;
        end else if (wr && wb_adr_i == `WFSU_CMD_OFS && wb_sel_i[0] &&
                     wb_dat_i[`WFSU_CMD_CANCEL_LSB + i]) begin
          armed_r[i] <= 1'b0;
        end else if (wr && wb_adr_i == (`WFSU_LVL0_OFS + i * 4)) begin
          reached_r[i] <= 1'b0;
        end
      end
    end
  end

  // Read data, captured with the acknowledge
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_dat_o <= `WFSU_ZERO32;
    end else if (req) begin
      case (wb_adr_i)
        `WFSU_CTRL_OFS: wb_dat_o <= ctrl_r;
        `WFSU_STAT_OFS: wb_dat_o <= {18'h0_0000, (dv_st_r == DV_BUSY), kilo,
                                     zero_track_en_o, use_wide, show_flow_r,
                                     flow_valid_r, reached_r, armed_r};
        `WFSU_THR_OFS: wb_dat_o <= thr_r;
        `WFSU_DERIV_OFS: wb_dat_o <= {16'h0000, td_neff_r};
        `WFSU_SRC_OFS: wb_dat_o <= {24'h00_0000, src_r};
        `WFSU_OMAP_OFS: wb_dat_o <= {20'h0_0000, omap_r};
        `WFSU_WGT_OFS: wb_dat_o <= weight_v;
        `WFSU_FLOW_OFS: wb_dat_o <= flow_r;
        `WFSU_DISP_OFS: wb_dat_o <= disp_v;
        `WFSU_LVL0_OFS: wb_dat_o <= level_r[0];
        `WFSU_LVL1_OFS: wb_dat_o <= level_r[1];
        `WFSU_LVL2_OFS: wb_dat_o <= level_r[2];
        `WFSU_LVL3_OFS: wb_dat_o <= level_r[3];
        default: wb_dat_o <= `WFSU_ZERO32;
      endcase
    end
  end

  // Flow scale factor: samples per second, time unit, decimals
  reg [31:0] k_time;
  reg [31:0] k_dec;
  reg [31:0] k_step;
  always @* begin
    case (scale)
      3'd1, 3'd3: k_time = `WFSU_SAMPLE_HZ * `WFSU_SEC_PER_MIN;
      3'd2, 3'd4: k_time = `WFSU_SAMPLE_HZ * `WFSU_SEC_PER_HOUR;
      default: k_time = `WFSU_SAMPLE_HZ;
    endcase
    case (dec)
      2'd1: k_dec = 32'd10;
      2'd2: k_dec = 32'd100;
      2'd3: k_dec = 32'd1000;
      default: k_dec = 32'd1;
    endcase
    case (stepc)
      2'd1: k_step = 32'd2;
      2'd2: k_step = 32'd5;
      2'd3: k_step = 32'd10;
      default: k_step = 32'd1;
    endcase
  end

  // Weight change across the derivation window
  wire [31:0] old_w = hist_r[ptr_r];
  wire [31:0] dw = weight_v - old_w;
  wire dw_neg = dw[31];
  wire [31:0] dw_abs = dw_neg ? (~dw + 32'h0000_0001) : dw;
  wire [63:0] k_all = k_time * k_dec;
  wire [63:0] num_v = dw_abs * k_all[31:0];
  wire [63:0] div_v = td_neff_r * k_step * (kilo ? `WFSU_KILO : 1);
  wire push = tick_r & flow_en & (ucnt_r == td_u_r - 9'h001);
  wire full = (fill_r == td_e_r);
  wire [32:0] rem_sh = {dv_rem_r[31:0], dv_quo_r[63]};
  wire rem_ge = rem_sh >= {1'b0, dv_div_r};
  wire [63:0] q_scaled = dv_quo_r * k_step;

  // History ring, one entry per update interval
  always @(posedge clk) begin
    if (push) begin
      hist_r[ptr_r] <= weight_v;
    end
  end

  // Ring pointers; restart after a new derivation time or flow off
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ptr_r <= 7'h00;
      fill_r <= 7'h00;
      ucnt_r <= 9'h000;
      flow_valid_r <= 1'b0;
    end else if (deriv_wr || !flow_en) begin
      ptr_r <= 7'h00;
      fill_r <= 7'h00;
      ucnt_r <= 9'h000;
      flow_valid_r <= 1'b0;
    end else if (tick_r) begin
      if (push) begin
        ucnt_r <= 9'h000;
        ptr_r <= (ptr_r == td_e_r - 7'h01) ? 7'h00 : ptr_r + 7'h01;
        if (!full) begin
          fill_r <= fill_r + 7'h01;
        end
        flow_valid_r <= full;
      end else begin
        ucnt_r <= ucnt_r + 9'h001;
      end
    end
  end

  // Serial divider, rounded quotient then multiplied by the step size.
  // Takes 65 cycles, far shorter than one sample period.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dv_st_r <= DV_IDLE;
      dv_cnt_r <= 7'h00;
      dv_quo_r <= 64'h0000_0000_0000_0000;
      dv_rem_r <= 33'h0_0000_0000;
      dv_div_r <= `WFSU_ZERO32;
      dv_neg_r <= 1'b0;
      flow_r <= `WFSU_ZERO32;
    end else begin
      case (dv_st_r)
        DV_IDLE: begin
          if (!flow_en) begin
            flow_r <= `WFSU_ZERO32;
          end else if (push && full) begin
            dv_quo_r <= num_v + {1'b0, div_v[63:1]};
            dv_div_r <= div_v[31:0];
            dv_neg_r <= dw_neg;
            dv_rem_r <= 33'h0_0000_0000;
            dv_cnt_r <= 7'h00;
            dv_st_r <= DV_BUSY;
          end
        end
        DV_BUSY: begin
          dv_rem_r <= rem_ge ? (rem_sh - {1'b0, dv_div_r}) : rem_sh;
          dv_quo_r <= {dv_quo_r[62:0], rem_ge};
          dv_cnt_r <= dv_cnt_r + 7'h01;
          if (dv_cnt_r == 7'd63) begin
            dv_st_r <= DV_IDLE;
          end
        end
        default: dv_st_r <= DV_IDLE;
      endcase
      if (dv_st_r == DV_IDLE && dv_cnt_r == 7'd64) begin
        flow_r <= dv_neg_r ? (~q_scaled[31:0] + 32'h0000_0001) : q_scaled[31:0];
        dv_cnt_r <= 7'h00;
      end
    end
  end

  // Flow settings are register-held from power-up; firmware restores them
  // from non-volatile storage after each power cycle

endmodule // wfsu_top

// >>> dv/wfsu_asserts.sv
`timescale 1ns/10ps
module wfsu_asserts #(
  parameter SAMPLE_CYC = 20
) (
  input wire clk,
  input wire nrst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire wf_toggle_key_i,
  input wire [3:0] dout_o,
  input wire zero_track_en_o,
  input wire show_flow_o,
  input wire flow_kilo_unit_o,
  input wire flow_valid_o,
  input wire sample_tick_o
);
  reg [31:0] gap_r;
  reg seen_r;
  reg [3:0] ticks_r;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // Clocks since last sample, and samples since reset
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap_r <= 32'h0000_0000;
      seen_r <= 1'b0;
      ticks_r <= 4'h0;
    end else begin
      gap_r <= sample_tick_o ? 32'h0000_0001 : gap_r + 32'h0000_0001;
      seen_r <= seen_r | sample_tick_o;
      if (sample_tick_o && ticks_r != 4'hf) begin
        ticks_r <= ticks_r + 4'h1;
      end
    end
  end

  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) // bus
    else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) // bus
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) // bus
    else $error("ack without request");
  a_tick_period: assert property (sample_tick_o && seen_r |-> gap_r == SAMPLE_CYC)
    else $error("sample spacing wrong");
  a_tick_gap: assert property (seen_r |-> gap_r <= SAMPLE_CYC)
    else $error("sample tick missing");
  a_dout_cause: assert property ($changed(dout_o) |-> wb_ack_o || $past(sample_tick_o))
    else $error("output changed without command or sample");
  a_zt_armed: assert property (|dout_o |-> !zero_track_en_o)
    else $error("zero tracking while armed");
  a_zt_cause: assert property ($changed(zero_track_en_o) |-> wb_ack_o || $past(sample_tick_o))
    else $error("zero tracking changed without cause");
  a_kilo_cause: assert property ($changed(flow_kilo_unit_o) |-> wb_ack_o)
    else $error("unit label changed without write");
  a_show_cause: assert property ($changed(show_flow_o) |->
    wb_ack_o || $past(wb_ack_o) || $past(wf_toggle_key_i, 3) || $past(wf_toggle_key_i, 4))
    else $error("display choice changed without cause");
  a_valid_early: assert property (flow_valid_o |-> ticks_r != 4'h0)
    else $error("flow valid before any sample");
endmodule // wfsu_asserts

bind wfsu_top wfsu_asserts #(.SAMPLE_CYC(SAMPLE_CYC)) i_wfsu_asserts (
  .clk(clk),
  .nrst(nrst),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .wf_toggle_key_i(wf_toggle_key_i),
  .dout_o(dout_o),
  .zero_track_en_o(zero_track_en_o),
  .show_flow_o(show_flow_o),
  .flow_kilo_unit_o(flow_kilo_unit_o),
  .flow_valid_o(flow_valid_o),
  .sample_tick_o(sample_tick_o)
);

// >>> dv/wfsu_master.sv
`timescale 1ns/10ps
module wfsu_master (
  input wire clk,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [31:0] dat_w,
  output logic [3:0] sel,
  input wire [31:0] dat_r,
  input wire ack
);
  // Idle bus from time zero
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat_w = 32'h0000_0000;
    sel = 4'h0;
  end

  // Classic cycle; entry edge leaves one idle cycle after the previous one
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= 4'hf;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
endmodule // wfsu_master

// >>> dv/testbench.sv
`timescale 1ns/10ps
`include "wfsu_defines.vh"
module testbench;
  logic clk;
  logic nrst;
  logic [23:0] raw_weight_i;
  logic wf_toggle_key_i;
  wire cyc, stb, we, ack;
  wire [7:0] adr;
  wire [31:0] dat_w, dat_r, weight_o, flow_o;
  wire [3:0] sel, dout_o;
  wire zero_track_en_o, show_flow_o, flow_kilo_unit_o, flow_valid_o, sample_tick_o;
  int n_mismatch;
  int tests_run;

  wfsu_top #(.SAMPLE_CYC(20)) i_wfsu_top (.clk(clk), .nrst(nrst), .wb_adr_i(adr),
    .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_ack_o(ack), .raw_weight_i(raw_weight_i),
    .wf_toggle_key_i(wf_toggle_key_i), .dout_o(dout_o), .zero_track_en_o(zero_track_en_o),
    .show_flow_o(show_flow_o), .flow_kilo_unit_o(flow_kilo_unit_o),
    .flow_valid_o(flow_valid_o), .sample_tick_o(sample_tick_o), .weight_o(weight_o),
    .flow_o(flow_o));
  wfsu_master i_wfsu_master (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .dat_w(dat_w), .sel(sel), .dat_r(dat_r), .ack(ack));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic finish_test;
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_wfsu_master.xfer(a, 1'b1, d, q);
  endtask

  // Masked register read compare
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    i_wfsu_master.xfer(a, 1'b0, 32'h0000_0000, q);
    chk(q & m, e);
  endtask

  // Let n samples pass, plus room for the update after the last one
  task automatic ticks(input int n);
    repeat (n) @(posedge clk iff sample_tick_o === 1'b1);
    repeat (3) @(posedge clk);
  endtask

  // Poll the fallback status bit until it reads e, at most n samples
  task automatic poll(input int n, input logic e);
    logic [31:0] q;
    logic hit;
    hit = 1'b0;
    repeat (n) begin
      if (!hit) begin
        ticks(1);
        i_wfsu_master.xfer(`WFSU_STAT_OFS, 1'b0, 32'h0000_0000, q);
        hit = (q[10] === e);
      end
    end
    chk(32'(hit), 32'h0000_0001);
  endtask

  // Hang guard, far beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    finish_test;
  end

  initial begin
    n_mismatch = 0;
    tests_run = 0;
    nrst = 1'b0;
    raw_weight_i = 24'h00_0000;
    wf_toggle_key_i = 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd(`WFSU_CTRL_OFS, 32'hffff_ffff, `WFSU_CTRL_RST);
    rd(`WFSU_THR_OFS, 32'hffff_ffff, `WFSU_THR_RST);
    rd(`WFSU_DERIV_OFS, 32'hffff_ffff, {16'h0000, `WFSU_DERIV_RST});
    rd(8'h2C, 32'hffff_ffff, 32'h0000_0000);
    wr(`WFSU_STAT_OFS, 32'hffff_ffff);
    rd(`WFSU_STAT_OFS, 32'h0000_00ff, 32'h0000_0000);
    // Four channels, each output mapped to its own channel
    wr(`WFSU_CTRL_OFS, 32'h0000_0020);
    wr(`WFSU_OMAP_OFS, 32'h0000_0fac);
    for (int i = 0; i < 4; i++) wr(`WFSU_LVL0_OFS + 8'(4 * i), 32'h0000_03e8);
    chk(32'(zero_track_en_o), 32'h0000_0001);
    wr(`WFSU_CMD_OFS, 32'h0000_000f);
    chk(32'(dout_o), 32'h0000_000f);
    chk(32'(zero_track_en_o), 32'h0000_0000);
    rd(`WFSU_STAT_OFS, 32'h0000_00ff, 32'h0000_000f);
    wr(`WFSU_CMD_OFS, 32'h0000_00f0);
    chk(32'(dout_o), 32'h0000_0000);
    rd(`WFSU_STAT_OFS, 32'h0000_00ff, 32'h0000_0000);
    // One-shot crossing on channel 2
    wr(`WFSU_LVL2_OFS, 32'h0000_0032);
    wr(`WFSU_CMD_OFS, 32'h0000_0004);
    raw_weight_i <= 24'h00_0064;
    ticks(6);
    chk(weight_o, 32'h0000_0064);
    chk(32'(dout_o), 32'h0000_0000);
    rd(`WFSU_STAT_OFS, 32'h0000_00ff, 32'h0000_0040);
    chk(32'(zero_track_en_o), 32'h0000_0001);
    wr(`WFSU_LVL2_OFS, 32'h0000_0032);
    rd(`WFSU_STAT_OFS, 32'h0000_00ff, 32'h0000_0000);
    wr(`WFSU_CMD_OFS, 32'h0000_0004);
    ticks(2);
    rd(`WFSU_STAT_OFS, 32'h0000_00ff, 32'h0000_0040);
    raw_weight_i <= 24'hff_ff9c;
    ticks(6);
    wr(`WFSU_CMD_OFS, 32'h0000_0004);
    rd(`WFSU_STAT_OFS, 32'h0000_00ff, 32'h0000_0004);
    wr(`WFSU_CMD_OFS, 32'h0000_0040);
    // Absolute weight as the compared signal on channel 1
    wr(`WFSU_LVL1_OFS, 32'h0000_0032);
    wr(`WFSU_CMD_OFS, 32'h0000_0002);
    ticks(4);
    chk(32'(dout_o), 32'h0000_0002);
    wr(`WFSU_SRC_OFS, 32'h0000_0004);
    ticks(3);
    rd(`WFSU_STAT_OFS, 32'h0000_00ff, 32'h0000_0020);
    wr(`WFSU_SRC_OFS, 32'h0000_0000);
    // Display toggle by command and key
    wr(`WFSU_CTRL_OFS, 32'h0000_0030);
    wr(`WFSU_CMD_OFS, 32'h0000_0100);
    repeat (2) @(posedge clk);
    chk(32'(show_flow_o), 32'h0000_0001);
    wf_toggle_key_i <= 1'b1;
    repeat (8) @(posedge clk);
    wf_toggle_key_i <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'(show_flow_o), 32'h0000_0000);
    wr(`WFSU_CTRL_OFS, 32'h0000_0020);
    wr(`WFSU_CMD_OFS, 32'h0000_0100);
    repeat (2) @(posedge clk);
    chk(32'(show_flow_o), 32'h0000_0000);
    // Every flow scale; only the two thousand-fold ones relabel
    for (int s = 0; s < 5; s++) begin
      wr(`WFSU_CTRL_OFS, 32'h0000_0030 | 32'(s << 6));
      chk(32'(flow_kilo_unit_o), 32'(s >= 3));
    end
    // Derivation time rounding above one hundred samples
    wr(`WFSU_DERIV_OFS, 32'h0000_00f0);
    rd(`WFSU_DERIV_OFS, 32'h0000_ffff, 32'h0000_00c8);
    wr(`WFSU_DERIV_OFS, 32'h0000_0104);
    rd(`WFSU_DERIV_OFS, 32'h0000_ffff, 32'h0000_012c);
    wr(`WFSU_CTRL_OFS, 32'h0000_0030);
    wr(`WFSU_DERIV_OFS, 32'h0000_0032);
    rd(`WFSU_DERIV_OFS, 32'h0000_ffff, 32'h0000_0032);
    wr(`WFSU_DERIV_OFS, 32'h0000_000a);
    repeat (2) @(posedge clk);
    chk(32'(flow_valid_o), 32'h0000_0000);
    ticks(14);
    repeat (80) @(posedge clk);
    chk(32'(flow_valid_o), 32'h0000_0001);
    chk(flow_o, 32'h0000_0000);
    // Step of 300 over a ten-sample window: per minute, one decimal, step 2
    wr(`WFSU_CTRL_OFS, 32'h0000_0a70);
    raw_weight_i <= 24'h00_00c8;
    ticks(10);
    chk(flow_o, 32'h0052_65c0);
    // Load step: no fallback at 2 Hz, fallback at the lowest bandwidth
    wr(`WFSU_CTRL_OFS, 32'h0000_0025);
    raw_weight_i <= 24'h00_0bb8;
    repeat (40) begin
      ticks(1);
      rd(`WFSU_STAT_OFS, 32'h0000_0400, 32'h0000_0000);
    end
    wr(`WFSU_CTRL_OFS, 32'h0000_0029);
    raw_weight_i <= 24'hff_ff9c;
    poll(70, 1'b1);
    poll(70, 1'b0);
    finish_test;
  end
endmodule // testbench
